/* File: inc/sptr_mem_if.sv */
// Port bundle between the interpreter and its slip buffer memory.
interface sptr_mem_if #(
	parameter int AW = 4
);
	logic wr_en;
	logic [AW-1:0] wr_addr;
	logic [7:0] wr_data;
	logic rd_en;
	logic [AW-1:0] rd_addr;
	logic [7:0] rd_data;

	modport ctl (
		output wr_en, wr_addr, wr_data, rd_en, rd_addr,
		input rd_data
	);
	modport mem (
		input wr_en, wr_addr, wr_data, rd_en, rd_addr,
		output rd_data
	);
endinterface : sptr_mem_if

/* File: inc/sptr_params.svh */
// Constants for the frame pointer interpreter and its slip buffer.
`ifndef SPTR_PARAMS_SVH
`define SPTR_PARAMS_SVH

// ---------------------------------------------------------------
// Frame geometry
// ---------------------------------------------------------------
`define SPTR_COLS 7'h5A
`define SPTR_ROWS 4'h9
`define SPTR_TOH_COLS 7'h03
`define SPTR_PTR_ROW 4'h3
`define SPTR_ENV_ROW_LEN 10'h057
`define SPTR_ENV_WRAP 10'h20A

// ---------------------------------------------------------------
// Framing pattern and loss count
// ---------------------------------------------------------------
`define SPTR_A1 8'hF6
`define SPTR_A2 8'h28
`define SPTR_MISS_LIMIT 3'h4

// ---------------------------------------------------------------
// Pointer word fields
// ---------------------------------------------------------------
`define SPTR_PTR_MAX 10'h30F
`define SPTR_I_MASK 10'h2AA
`define SPTR_D_MASK 10'h155
`define SPTR_STUFF_BYTE 8'h00

`endif

/* File: inc/sptr_pkg.sv */
// Types shared by the pointer interpreter modules.
package sptr_pkg;

	// Frame alignment states.
	typedef enum logic [1:0] {
		SPTR_HUNT = 2'b00,
		SPTR_PRESYNC = 2'b01,
		SPTR_SYNC = 2'b10
	} sptr_align_t;

	// Pointer adjustment waiting to be applied in the next frame.
	typedef enum logic [1:0] {
		SPTR_ADJ_NONE = 2'b00,
		SPTR_ADJ_INC = 2'b01,
		SPTR_ADJ_DEC = 2'b10
	} sptr_adj_t;

endpackage : sptr_pkg

/* File: rtl/sptr_pointer_interp.sv */
// Frame aligner, payload pointer interpreter and slip buffer control.
`include "sptr_params.svh"

module sptr_pointer_interp #(
	parameter int AW = 4,
	parameter int LOW_FILL = 2
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rstn,
	// Incoming byte stream, one strobe per f1 byte.
	input wire logic in_valid,
	input wire logic [7:0] in_byte,
	// Outgoing byte stream, one strobe per f2 byte.
	input wire logic out_ready,
	output logic out_valid,
	output logic [7:0] out_byte,
	output logic out_stuff,
	// Alignment and pointer status.
	output logic in_sync,
	output logic [9:0] ptr_value,
	output logic ptr_ok,
	output logic ptr_invalid,
	output logic ptr_inc,
	output logic ptr_dec,
	output logic j1_mark,
	output logic slip_overflow
);
	typedef struct packed {
		sptr_pkg::sptr_align_t st;
		logic [2:0] miss;
		logic [6:0] col;
		logic [3:0] row;
		logic [7:0] prev;
		logic [7:0] h1;
		logic [9:0] ptr;
		logic ptr_ok;
		sptr_pkg::sptr_adj_t adj;
		logic inv;
		logic inc;
		logic dec;
		logic j1;
		logic ovf;
		logic [AW:0] wr_ptr;
		logic [AW:0] rd_ptr;
		logic out_valid;
		logic out_stuff;
	} sptr_state_t;

	sptr_state_t s;
	sptr_state_t next_s;
	sptr_mem_if #(.AW(AW)) mif ();

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------

	// Envelope offset of a byte at a given row and column.
	function automatic logic [9:0] env_off(input logic [3:0] row,
			input logic [6:0] col);
		logic [9:0] r;
		logic [9:0] c;
		r = 10'(row);
		c = 10'(col) - 10'(`SPTR_TOH_COLS);
		if (row >= `SPTR_PTR_ROW) begin
			env_off = 10'((r - 10'(`SPTR_PTR_ROW)) * `SPTR_ENV_ROW_LEN + c);
		end else begin
			env_off = 10'(`SPTR_ENV_WRAP + r * `SPTR_ENV_ROW_LEN + c);
		end
	endfunction : env_off

	// True when three or more of the five masked bits are inverted.
	function automatic logic most_set(input logic [9:0] x,
			input logic [9:0] mask);
		logic [9:0] y;
		logic [2:0] n;
		y = x & mask;
		n = 3'h0;
		for (int k = 0; k < 10; k++) begin
			n = n + 3'(y[k]);
		end
		most_set = (n >= 3'h3);
	endfunction : most_set

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		logic [9:0] word;
		logic [9:0] diff;
		logic [AW:0] fill;
		logic a_hit;
		word = {s.h1[1:0], in_byte};
		diff = word ^ s.ptr;
		fill = s.wr_ptr - s.rd_ptr;
		a_hit = (s.prev == `SPTR_A1) && (in_byte == `SPTR_A2);
		next_s = s;
		next_s.inv = 1'b0;
		next_s.inc = 1'b0;
		next_s.dec = 1'b0;
		next_s.j1 = 1'b0;
		next_s.ovf = 1'b0;
		next_s.out_valid = 1'b0;
		next_s.out_stuff = 1'b0;
		mif.wr_en = 1'b0;
		mif.wr_addr = s.wr_ptr[AW-1:0];
		mif.wr_data = in_byte;
		mif.rd_en = 1'b0;
		mif.rd_addr = s.rd_ptr[AW-1:0];
		if (in_valid) begin
			next_s.prev = in_byte;
			// Column and row counters walk the frame byte by byte.
			if (s.col == `SPTR_COLS - 7'h01) begin
				next_s.col = 7'h00;
				next_s.row = (s.row == `SPTR_ROWS - 4'h1) ? 4'h0 :
					s.row + 4'h1;
			end else begin
				next_s.col = s.col + 7'h01;
			end
			// Framing pattern checked where it is expected.
			if (s.st == sptr_pkg::SPTR_HUNT) begin
				if (a_hit) begin
					next_s.st = sptr_pkg::SPTR_PRESYNC;
					next_s.col = 7'h02;
					next_s.row = 4'h0;
				end
			end else if (s.row == 4'h0 && s.col == 7'h01) begin
				if (a_hit) begin
					next_s.st = sptr_pkg::SPTR_SYNC;
					next_s.miss = 3'h0;
				end else if (s.st == sptr_pkg::SPTR_PRESYNC ||
						s.miss + 3'h1 >= `SPTR_MISS_LIMIT) begin
					next_s.st = sptr_pkg::SPTR_HUNT;
					next_s.miss = 3'h0;
					next_s.ptr_ok = 1'b0;
					next_s.adj = sptr_pkg::SPTR_ADJ_NONE;
				end else begin
					next_s.miss = s.miss + 3'h1;
				end
			end
			// Pointer bytes are read only while in frame.
			if (s.st == sptr_pkg::SPTR_SYNC &&
					s.row == `SPTR_PTR_ROW) begin
				if (s.col == 7'h00) begin
					next_s.h1 = in_byte;
				end else if (s.col == 7'h01) begin
					if (s.adj == sptr_pkg::SPTR_ADJ_INC) begin
						// Apply the increment seen one frame ago.
						next_s.ptr = (s.ptr == `SPTR_PTR_MAX) ? 10'h000 :
							s.ptr + 10'h001;
						next_s.adj = sptr_pkg::SPTR_ADJ_NONE;
					end else if (s.adj == sptr_pkg::SPTR_ADJ_DEC) begin
						// Apply the decrement seen one frame ago.
						next_s.ptr = (s.ptr == 10'h000) ? `SPTR_PTR_MAX :
							s.ptr - 10'h001;
						next_s.adj = sptr_pkg::SPTR_ADJ_NONE;
					end else if (s.ptr_ok && most_set(diff, `SPTR_I_MASK) &&
							!most_set(diff, `SPTR_D_MASK)) begin
						next_s.inc = 1'b1; // Inverted I bits.
						next_s.adj = sptr_pkg::SPTR_ADJ_INC;
					end else if (s.ptr_ok && most_set(diff, `SPTR_D_MASK) &&
							!most_set(diff, `SPTR_I_MASK)) begin
						next_s.dec = 1'b1; // Inverted D bits.
						next_s.adj = sptr_pkg::SPTR_ADJ_DEC;
					end else if (word > `SPTR_PTR_MAX) begin
						next_s.inv = 1'b1; // Out of range, kept out.
					end else begin
						next_s.ptr = word; // Low ten bits of H1:H2.
						next_s.ptr_ok = 1'b1;
					end
				end
			end
			// J1 found where the envelope offset equals the pointer.
			if (s.st == sptr_pkg::SPTR_SYNC && s.ptr_ok &&
					s.col >= `SPTR_TOH_COLS &&
					env_off(s.row, s.col) == s.ptr) begin
				next_s.j1 = 1'b1;
			end
			// Every f1 byte enters the slip buffer unless it is full.
			if (fill[AW]) begin
				next_s.ovf = 1'b1;
			end else begin
				mif.wr_en = 1'b1;
				next_s.wr_ptr = s.wr_ptr + (AW+1)'(1);
			end
		end
		// Each f2 strobe takes one byte or inserts a stuff byte.
		if (out_ready) begin
			next_s.out_valid = 1'b1;
			if (fill <= (AW+1)'(LOW_FILL)) begin
				next_s.out_stuff = 1'b1; // Dummy byte, flagged.
			end else begin
				mif.rd_en = 1'b1; // Steady fill stuffs nothing.
				next_s.rd_ptr = s.rd_ptr + (AW+1)'(1);
			end
		end
	end

	// State register.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// Slip buffer storage.
	sptr_slip_mem #(.AW(AW)) u_mem (
		.clk(clk),
		.rstn(rstn),
		.m(mif.mem)
	);

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------

	// Stuff bytes carry a fixed value in place of buffer data.
	assign out_valid = s.out_valid;
	assign out_stuff = s.out_stuff;
	assign out_byte = s.out_stuff ? `SPTR_STUFF_BYTE : mif.rd_data;
	assign in_sync = (s.st == sptr_pkg::SPTR_SYNC);
	assign ptr_value = s.ptr;
	assign ptr_ok = s.ptr_ok;
	assign ptr_invalid = s.inv;
	assign ptr_inc = s.inc;
	assign ptr_dec = s.dec;
	assign j1_mark = s.j1;
	assign slip_overflow = s.ovf;

endmodule : sptr_pointer_interp

/* File: rtl/sptr_slip_mem.sv */
// Slip buffer storage with one write port and a registered read port.
module sptr_slip_mem #(
	parameter int AW = 4
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rstn,
	// Memory port.
	sptr_mem_if.mem m
);
	localparam int DEPTH = 1 << AW;

	typedef struct packed {
		logic [DEPTH-1:0][7:0] mem;
		logic [7:0] rd_data;
	} sptr_mem_state_t;

	sptr_mem_state_t s;
	sptr_mem_state_t next_s;

	// Write stores a byte, read loads the output register.
	always_comb begin
		next_s = s;
		if (m.wr_en) begin
			next_s.mem[m.wr_addr] = m.wr_data;
		end
		if (m.rd_en) begin
			next_s.rd_data = s.mem[m.rd_addr];
		end
	end

	// State register.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign m.rd_data = s.rd_data;

endmodule : sptr_slip_mem

/* File: testbench/sptr_pointer_interp_properties.sv */
// Port timing checks for the pointer interpreter.
module sptr_pointer_interp_properties (
	// Watched ports.
	input wire logic clk, rstn, in_valid, out_ready, out_valid,
	input wire logic [7:0] in_byte, out_byte,
	input wire logic out_stuff, in_sync, ptr_ok, ptr_invalid,
	input wire logic ptr_inc, ptr_dec, j1_mark, slip_overflow,
	input wire logic [9:0] ptr_value
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// Reads answer in the next cycle only.
	property p_rd; out_ready |=> out_valid; endproperty
	a_rd: assert property (p_rd) else $error("read not answered");
	property p_nord; !out_ready |=> !out_valid; endproperty
	a_nord: assert property (p_nord) else $error("stray out_valid");
	// An inserted byte is flagged and carries the stuff value.
	property p_stuff; out_stuff |-> out_valid && out_byte == 8'h00; endproperty
	a_stuff: assert property (p_stuff) else $error("bad stuff");
	// A rejected word leaves the pointer alone.
	property p_inv; ptr_invalid |-> $stable(ptr_value); endproperty
	a_inv: assert property (p_inv) else $error("pointer moved");
	property p_max; ptr_value <= 10'h30F; endproperty
	a_max: assert property (p_max) else $error("pointer range");
	// J1 is only located once aligned and pointed.
	property p_j1; j1_mark |-> in_sync && ptr_ok; endproperty
	a_j1: assert property (p_j1) else $error("early j1_mark");
	// Status only moves after an input byte.
	property p_hold;
		!$past(in_valid) |-> $stable(ptr_value) && $stable(in_sync);
	endproperty
	a_hold: assert property (p_hold) else $error("status moved");
	property p_adj;
		ptr_inc || ptr_dec |-> $past(in_valid) && ptr_ok && !(ptr_inc && ptr_dec);
	endproperty
	a_adj: assert property (p_adj) else $error("bad adjust");
	property p_ovf; slip_overflow |-> $past(in_valid); endproperty
	a_ovf: assert property (p_ovf) else $error("stray overflow");
	// Main scenarios reached.
	c_stuff: cover property (out_stuff);
	c_ovf: cover property (slip_overflow);
	c_inc: cover property (ptr_inc);
	c_dec: cover property (ptr_dec);
endmodule : sptr_pointer_interp_properties

bind sptr_pointer_interp sptr_pointer_interp_properties u_props (
	.clk(clk), .rstn(rstn), .in_valid(in_valid), .out_ready(out_ready),
	.out_valid(out_valid), .in_byte(in_byte), .out_byte(out_byte),
	.out_stuff(out_stuff), .in_sync(in_sync), .ptr_ok(ptr_ok),
	.ptr_invalid(ptr_invalid), .ptr_inc(ptr_inc), .ptr_dec(ptr_dec),
	.j1_mark(j1_mark), .slip_overflow(slip_overflow), .ptr_value(ptr_value)
);

/* File: testbench/sptr_pointer_interp_tb_top.sv */
// Self-checking bench for the pointer interpreter.
module sptr_pointer_interp_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rstn = 0, out_ready = 0, run = 0, ld = 0;
	logic [9:0] ptr_set = 0, ptr_value;
	logic [1:0] adj = 0;
	logic in_valid, out_valid, out_stuff, in_sync, ptr_ok, ptr_invalid;
	logic ptr_inc, ptr_dec, j1_mark, slip_overflow;
	logic [7:0] in_byte, out_byte, ex;
	int error_cnt = 0, checked = 0, i, k;
	// Free running clock.
	always #20 clk = ~clk;
	sptr_up_model u_src (.clk(clk), .rstn(rstn), .run(run), .ld(ld),
		.ptr_set(ptr_set), .adj(adj), .in_valid(in_valid), .in_byte(in_byte));
	sptr_pointer_interp #(.AW(4), .LOW_FILL(2)) u_dut (.clk(clk), .rstn(rstn),
		.in_valid(in_valid), .in_byte(in_byte), .out_ready(out_ready),
		.out_valid(out_valid), .out_byte(out_byte), .out_stuff(out_stuff),
		.in_sync(in_sync), .ptr_value(ptr_value), .ptr_ok(ptr_ok),
		.ptr_invalid(ptr_invalid), .ptr_inc(ptr_inc), .ptr_dec(ptr_dec),
		.j1_mark(j1_mark), .slip_overflow(slip_overflow));
	task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask : cmp
	task end_of_test;
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : end_of_test
	// Empty buffer read gives a flagged stuff byte.
	task t_stuff;
		@(posedge clk) out_ready <= 1'b1;
		@(posedge clk) out_ready <= 1'b0;
		@(negedge clk);
		cmp("out_valid", 1, out_valid);
		cmp("stuff", 16'h0100, {out_stuff, out_byte});
		$display("stuff test done");
	endtask : t_stuff
	// Align, read, reject, then step the pointer up and down.
	task t_ptr;
		@(posedge clk) {run, ld, ptr_set} <= {2'b11, 10'h005};
		@(posedge clk) ld <= 1'b0;
		for (i = 0; i < 2000 && in_sync !== 1'b1; i++) @(negedge clk);
		cmp("in_sync", 1, in_sync);
		for (i = 0; i < 1000 && ptr_ok !== 1'b1; i++) @(negedge clk);
		cmp("ptr_ok", 1, ptr_ok);
		cmp("ptr_value", 10'h005, ptr_value);
		// J1 for pointer 5 sits at row 3, column 8; the source shows column 9 next.
		for (i = 0; i < 1000 && j1_mark !== 1'b1; i++) @(negedge clk);
		cmp("j1_next_byte", 16'h0009, in_byte);
		// The mark comes once per frame of 810 bytes.
		@(negedge clk);
		for (i = 1; i < 1000 && j1_mark !== 1'b1; i++) @(negedge clk);
		cmp("j1_gap", 16'h032A, i[15:0]);
		@(posedge clk) {ld, ptr_set} <= {1'b1, 10'h315};
		@(posedge clk) ld <= 1'b0;
		for (i = 0; i < 1700 && ptr_invalid !== 1'b1; i++) @(negedge clk);
		cmp("ptr_invalid", 1, ptr_invalid);
		cmp("ptr_value", 10'h005, ptr_value);
		@(posedge clk) {ld, ptr_set, adj} <= {1'b1, 10'h005, 2'h1};
		@(posedge clk) ld <= 1'b0;
		for (i = 0; i < 1700 && ptr_inc !== 1'b1; i++) @(negedge clk);
		cmp("ptr_inc", 1, ptr_inc);
		@(posedge clk) adj <= 2'h0;
		for (i = 0; i < 1700 && ptr_value !== 10'h006; i++) @(negedge clk);
		cmp("ptr_value", 10'h006, ptr_value);
		@(posedge clk) adj <= 2'h2;
		for (i = 0; i < 1700 && ptr_dec !== 1'b1; i++) @(negedge clk);
		cmp("ptr_dec", 1, ptr_dec);
		@(posedge clk) adj <= 2'h0;
		for (i = 0; i < 1700 && ptr_value !== 10'h005; i++) @(negedge clk);
		cmp("ptr_value", 10'h005, ptr_value);
		$display("pointer test done");
	endtask : t_ptr
	// Full buffer drains oldest first, then stuffs at the low mark.
	task t_fifo;
		// No reads ran during the pointer test, so the buffer is full.
		cmp("slip_overflow", 1, slip_overflow);
		@(posedge clk) {run, out_ready} <= 2'b01;
		for (k = 0; k < 16; k++) begin
			@(posedge clk);
			if (k == 15) out_ready <= 1'b0;
			@(negedge clk);
			ex = k == 0 ? 8'hF6 : k == 1 ? 8'h28 : k < 14 ? k[7:0] : 8'h00;
			cmp("out_byte", {8'h00, ex}, out_byte);
			cmp("out_stuff", k >= 14, out_stuff);
		end
		$display("buffer test done");
	endtask : t_fifo
	// Reset, run the scenarios, report.
	initial begin
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		@(negedge clk);
		cmp("outputs", 0, {out_valid, out_stuff, in_sync, ptr_ok, ptr_value});
		t_stuff();
		t_ptr();
		t_fifo();
		end_of_test();
	end
	// Watchdog against a hang.
	initial begin
		#800000;
		error_cnt++;
		end_of_test();
	end
endmodule : sptr_pointer_interp_tb_top

/* File: testbench/sptr_up_model.sv */
// Upstream frame source sending back-to-back frames.
`include "sptr_params.svh"
module sptr_up_model (
	// Clock, reset and bench control.
	input wire logic clk,
	input wire logic rstn,
	input wire logic run,
	input wire logic ld,
	input wire logic [9:0] ptr_set,
	input wire logic [1:0] adj,
	// Byte stream.
	output logic in_valid,
	output logic [7:0] in_byte
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [6:0] col;
	logic [3:0] row;
	logic [9:0] cur;
	logic [1:0] pend;
	logic [9:0] p;
	logic fs;
	// Sent pointer bits, I or D bits inverted in a stuff frame.
	assign p = pend == 2'h1 ? cur ^ `SPTR_I_MASK :
		pend == 2'h2 ? cur ^ `SPTR_D_MASK : cur;
	assign fs = row == 4'h0 && col == 7'h00;
	// Frame byte sequencer; an idle line toggles so it never looks held.
	always_ff @(posedge clk) begin
		if (!rstn || !run) begin
			in_valid <= 1'b0;
			col <= 7'h00;
			row <= 4'h0;
			pend <= 2'h0;
			// Reset gives the line a known value, so the toggle is never X.
			in_byte <= rstn ? ~in_byte : 8'h00;
		end else begin
			in_valid <= 1'b1;
			col <= col == 7'h59 ? 7'h00 : col + 7'h01;
			if (col == 7'h59) begin
				row <= row == 4'h8 ? 4'h0 : row + 4'h1;
			end
			in_byte <= fs ? `SPTR_A1 : row == 4'h0 && col == 7'h01 ? `SPTR_A2 :
				row == 4'h3 && col == 7'h00 ? {6'h18, p[9:8]} :
				row == 4'h3 && col == 7'h01 ? p[7:0] : {1'b0, col};
			// The frame after a stuff frame carries the moved pointer.
			if (fs) begin
				cur <= pend == 2'h1 ? cur + 10'h001 :
					pend == 2'h2 ? cur - 10'h001 : cur;
				pend <= pend != 2'h0 ? 2'h0 : adj;
			end
		end
		if (ld) begin
			cur <= ptr_set;
		end
	end
endmodule : sptr_up_model
